// ---- hdl/dchan_pkg.sv ----
package dchan_pkg;
  localparam logic [5:0] RX_FIFO_OFFSET   = 6'h00;
  localparam logic [5:0] TX_FIFO_OFFSET   = 6'h01;
  localparam logic [5:0] COMMAND_OFFSET   = 6'h02;
  localparam logic [5:0] MODE_OFFSET      = 6'h03;
  localparam logic [5:0] COUNT_HIGH_OFFSET = 6'h16;
  localparam logic [5:0] COUNT_LOW_OFFSET  = 6'h17;
  localparam logic [5:0] TIMER1_OFFSET    = 6'h38;
  localparam int RX_ACK_BIT       = 7;
  localparam int RX_RESET_BIT     = 6;
  localparam int TIMER1_START_BIT = 4;
  localparam int TX_START_BIT     = 3;
  localparam int TX_END_BIT       = 1;
  localparam int TX_RESET_BIT     = 0;
  localparam int RX_ACTIVE_BIT    = 7;
  localparam int TX_ACTIVE_BIT    = 6;
  localparam logic [7:0] COMMAND_RESET = 8'h00;
  localparam logic [7:0] MODE_RESET    = 8'h00;
  localparam logic [7:0] TIMER1_RESET  = 8'h00;
  localparam int FIFO_BYTES  = 64;
  localparam int BLOCK_BYTES = 32;
  localparam logic [7:0] HDLC_FLAG = 8'h7e;
  localparam logic [15:0] CRC_POLY_REV = 16'h8408;
  localparam logic [15:0] CRC_INIT     = 16'hffff;
  localparam int TIMER1_TICK_NS = 1000;
  localparam int CLOCK_NS       = 25;
  localparam int TIMER1_TICK_CYCLES = TIMER1_TICK_NS / CLOCK_NS;
endpackage

// ---- hdl/byte_ram.sv ----
`timescale 1ns/100ps
module byte_ram #(
  parameter int DEPTH = 64,
  parameter int AW    = 6
) (
  input  wire logic          core_clk,
  input  wire logic          ce,
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] wr_addr,
  input  wire logic [7:0]    wr_data,
  input  wire logic [AW-1:0] rd_addr,
  output logic      [7:0]    rd_data
);
  logic [7:0] mem [DEPTH];
  always_ff @(posedge core_clk) begin
    if (ce && wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end
  always_ff @(posedge core_clk) begin
    if (ce) begin
      rd_data <= mem[rd_addr];
    end
  end
endmodule

// ---- hdl/dchan_hdlc_fifo_command.sv ----
`timescale 1ns/100ps
module dchan_hdlc_fifo_command #(
  parameter int FIFO_DEPTH = 64,
  parameter int AW         = 6
) (
  input  wire logic       core_clk,
  input  wire logic       nrst,
  input  wire logic       ce,
  input  wire logic       cs_n,
  input  wire logic       rd_n,
  input  wire logic       wr_n,
  input  wire logic [5:0] addr,
  input  wire logic [7:0] wdata,
  output logic      [7:0] rdata,
  input  wire logic       line_rx_bit,
  input  wire logic       line_rx_valid,
  input  wire logic       line_rx_frame_end,
  output logic            line_tx_bit,
  output logic            line_tx_bit_strobe,
  output logic            rx_block_ready_irq,
  output logic            rx_frame_end_irq,
  output logic            tx_fifo_ready_irq,
  output logic            timer1_expired
);
  typedef enum logic [4:0] {
    TX_IDLE = 5'b00001, TX_OPEN = 5'b00010, TX_DATA = 5'b00100,
    TX_CRC  = 5'b01000, TX_CLOSE = 5'b10000
  } tx_state_type;

  // pins come from outside the clock domain
  logic [1:0] cs_sync, rd_sync, wr_sync, rxb_sync, rxv_sync, rxe_sync;
  logic [5:0] addr_s1, addr_reg;
  logic [7:0] wd_s1, wd_reg;
  logic       rd_d, wr_d, rxv_d, rxe_d;
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      cs_sync <= 2'b11; rd_sync <= 2'b11; wr_sync <= 2'b11;
      rxb_sync <= '0; rxv_sync <= '0; rxe_sync <= '0;
      addr_s1 <= '0; addr_reg <= '0; wd_s1 <= '0; wd_reg <= '0;
      rd_d <= 1'b0; wr_d <= 1'b0; rxv_d <= 1'b0; rxe_d <= 1'b0;
    end else if (ce) begin
      cs_sync <= {cs_sync[0], cs_n}; rd_sync <= {rd_sync[0], rd_n};
      wr_sync <= {wr_sync[0], wr_n}; rxb_sync <= {rxb_sync[0], line_rx_bit};
      rxv_sync <= {rxv_sync[0], line_rx_valid};
      rxe_sync <= {rxe_sync[0], line_rx_frame_end};
      addr_s1 <= addr; addr_reg <= addr_s1; wd_s1 <= wdata; wd_reg <= wd_s1;
      rd_d <= !cs_sync[1] && !rd_sync[1]; wr_d <= !cs_sync[1] && !wr_sync[1];
      rxv_d <= rxv_sync[1]; rxe_d <= rxe_sync[1];
    end
  end
  logic rd_now, wr_now, rd_pulse, wr_pulse, rxv_pulse, rxe_pulse;
  assign rd_now    = !cs_sync[1] && !rd_sync[1];
  assign wr_now    = !cs_sync[1] && !wr_sync[1];
  // bus strobes act once on the trailing edge so address and data are settled; line valid and frame end act on the leading edge
  assign rd_pulse  = rd_d && !rd_now;
  assign wr_pulse  = wr_d && !wr_now;
  assign rxv_pulse = rxv_sync[1] && !rxv_d;
  assign rxe_pulse = rxe_sync[1] && !rxe_d;

  logic       wr_cmd, wr_txf, wr_mode, wr_tim, rd_rxf;
  assign wr_cmd  = wr_pulse && addr_reg == dchan_pkg::COMMAND_OFFSET;
  assign wr_txf  = wr_pulse && addr_reg == dchan_pkg::TX_FIFO_OFFSET;
  assign wr_mode = wr_pulse && addr_reg == dchan_pkg::MODE_OFFSET;
  assign wr_tim  = wr_pulse && addr_reg == dchan_pkg::TIMER1_OFFSET;
  assign rd_rxf  = rd_pulse && addr_reg == dchan_pkg::RX_FIFO_OFFSET;
  logic rx_ack, rx_rst, t1_go, tx_go, tx_end, tx_rst;
  // commands act as one-cycle pulses, nothing is stored: reads as zero
  assign rx_ack = wr_cmd && wd_reg[dchan_pkg::RX_ACK_BIT];
  assign rx_rst = wr_cmd && wd_reg[dchan_pkg::RX_RESET_BIT];
  assign t1_go  = wr_cmd && wd_reg[dchan_pkg::TIMER1_START_BIT];
  assign tx_go  = wr_cmd && wd_reg[dchan_pkg::TX_START_BIT];
  assign tx_end = wr_cmd && wd_reg[dchan_pkg::TX_END_BIT];
  assign tx_rst = wr_cmd && wd_reg[dchan_pkg::TX_RESET_BIT];

  logic [7:0] mode_reg, timer1_reg;
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      mode_reg   <= dchan_pkg::MODE_RESET;
      timer1_reg <= dchan_pkg::TIMER1_RESET;
    end else if (ce) begin
      if (wr_mode) mode_reg <= wd_reg;
      if (wr_tim) timer1_reg <= wd_reg;
    end
  end

  // timer 1: counts timer1_reg[6:0] + 1 ticks
  logic        t1_run;
  logic [6:0]  t1_left;
  logic [15:0] t1_pre;
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      t1_run <= 1'b0; t1_left <= '0; t1_pre <= '0; timer1_expired <= 1'b0;
    end else if (ce) begin
      timer1_expired <= 1'b0;
      if (wr_tim) begin
        t1_run <= 1'b0;
      end else if (t1_go) begin
        t1_run <= 1'b1; t1_left <= timer1_reg[6:0]; t1_pre <= '0;
      end else if (t1_run) begin
        if (t1_pre == 16'(dchan_pkg::TIMER1_TICK_CYCLES - 1)) begin
          t1_pre <= '0;
          if (t1_left == '0) begin
            t1_run <= 1'b0; timer1_expired <= 1'b1;
          end else begin
            t1_left <= t1_left - 7'd1;
          end
        end else begin
          t1_pre <= t1_pre + 16'd1;
        end
      end
    end
  end

  // receive path: deserialise bits into the ring
  logic [AW-1:0] rx_wp, rx_rp, rx_ackp;
  logic [AW:0]   rx_pend;
  logic [2:0]    rx_bitc;
  logic [7:0]    rx_shift;
  logic          rx_we;
  logic [12:0]   rx_len;
  logic [7:0]    rx_rdata, rx_hi_reg, rx_lo_reg;
  logic [AW:0]   rx_blk;
  assign rx_we = rxv_pulse && mode_reg[dchan_pkg::RX_ACTIVE_BIT] && rx_bitc == 3'd7;
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      rx_wp <= '0; rx_rp <= '0; rx_ackp <= '0; rx_bitc <= '0; rx_shift <= '0;
      rx_len <= '0; rx_blk <= '0; rx_hi_reg <= '0; rx_lo_reg <= '0;
      rx_block_ready_irq <= 1'b0; rx_frame_end_irq <= 1'b0;
    end else if (ce) begin
      rx_block_ready_irq <= 1'b0;
      rx_frame_end_irq   <= 1'b0;
      if (rx_rst) begin
        rx_wp <= '0; rx_rp <= '0; rx_ackp <= '0; rx_bitc <= '0;
        rx_len <= '0; rx_blk <= '0;
      end else begin
        if (rxv_pulse && mode_reg[dchan_pkg::RX_ACTIVE_BIT]) begin
          rx_shift <= {rxb_sync[1], rx_shift[7:1]};
          rx_bitc  <= rx_bitc + 3'd1;
        end
        if (rx_we) begin
          rx_wp  <= rx_wp + 1'b1;
          rx_len <= rx_len + 13'd1;
          if (rx_blk == (AW+1)'(dchan_pkg::BLOCK_BYTES - 1)) begin
            rx_blk <= '0;
            rx_block_ready_irq <= 1'b1;
          end else begin
            rx_blk <= rx_blk + 1'b1;
          end
        end else if (rxe_pulse && mode_reg[dchan_pkg::RX_ACTIVE_BIT]) begin
          rx_hi_reg <= {3'b000, rx_len[12:8]};
          rx_lo_reg <= rx_len[7:0]; // low five bits = residue, 0 means 32
          rx_len <= '0; rx_blk <= '0; rx_bitc <= '0;
          rx_frame_end_irq <= 1'b1;
        end
        if (rd_rxf) rx_rp <= rx_rp + 1'b1;
        if (rx_ack) rx_ackp <= rx_rp; // space freed once acknowledged
      end
    end
  end
  assign rx_pend = {1'b0, rx_wp - rx_ackp};

  byte_ram #(.DEPTH(FIFO_DEPTH), .AW(AW)) rx_ram (
    .core_clk (core_clk),
    .ce       (ce),
    .wr_en    (rx_we),
    .wr_addr  (rx_wp),
    .wr_data  ({rxb_sync[1], rx_shift[7:1]}),
    .rd_addr  (rx_rp),
    .rd_data  (rx_rdata)
  );

  // transmit path
  logic [AW-1:0] tx_wp, tx_rp;
  logic [AW:0]   tx_cnt;
  logic [7:0]    tx_rdata, tx_sh;
  logic [2:0]    tx_bitc;
  logic [15:0]   crc;
  logic          tx_end_pend, tx_crc_hi, tx_pop, tx_push;
  logic          tx_data_bit;
  tx_state_type  tx_state;
  assign tx_data_bit = tx_sh[0];
  // a full fifo drops the byte rather than overwrite unsent data
  assign tx_push = wr_txf && tx_cnt != (AW+1)'(FIFO_DEPTH);
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      tx_wp <= '0; tx_cnt <= '0; tx_state <= TX_IDLE; tx_bitc <= '0; tx_sh <= '1;
      crc <= dchan_pkg::CRC_INIT; tx_end_pend <= 1'b0; tx_crc_hi <= 1'b0;
      tx_rp <= '0; tx_pop <= 1'b0;
      line_tx_bit <= 1'b1; line_tx_bit_strobe <= 1'b0; tx_fifo_ready_irq <= 1'b1;
    end else if (ce) begin
      tx_fifo_ready_irq  <= 1'b0;
      line_tx_bit_strobe <= 1'b0;
      tx_pop <= 1'b0;
      if (tx_rst) begin
        tx_wp <= '0; tx_rp <= '0; tx_cnt <= '0; tx_end_pend <= 1'b0;
        tx_state <= TX_IDLE; tx_bitc <= '0;
        line_tx_bit <= 1'b1; // idle fill of ones
        tx_fifo_ready_irq <= 1'b1;
      end else begin
        if (tx_push) tx_wp <= tx_wp + 1'b1;
        if (tx_end) tx_end_pend <= 1'b1;
        tx_cnt <= tx_cnt + (AW+1)'(tx_push) - (AW+1)'(tx_pop);
        line_tx_bit_strobe <= tx_state != TX_IDLE; // idle fill is not strobed
        tx_bitc <= tx_bitc + 3'd1;
        case (tx_state)
          TX_IDLE: begin
            line_tx_bit <= 1'b1;
            tx_bitc <= '0;
            if (tx_go) begin
              tx_state <= TX_OPEN; tx_sh <= dchan_pkg::HDLC_FLAG;
              crc <= dchan_pkg::CRC_INIT;
            end
          end
          TX_OPEN, TX_CLOSE: begin
            line_tx_bit <= tx_data_bit;
            tx_sh <= {1'b1, tx_sh[7:1]};
            if (tx_bitc == 3'd7) begin
              if (tx_state == TX_CLOSE) begin
                tx_state <= TX_IDLE; tx_end_pend <= 1'b0;
                tx_fifo_ready_irq <= 1'b1;
              end else begin
                tx_state <= TX_DATA; tx_sh <= tx_rdata; tx_pop <= 1'b1;
                tx_rp <= tx_rp + 1'b1;
              end
            end
          end
          TX_DATA: begin
            line_tx_bit <= tx_data_bit;
            tx_sh <= {1'b1, tx_sh[7:1]};
            crc <= (crc >> 1) ^ ((crc[0] ^ tx_data_bit) ? dchan_pkg::CRC_POLY_REV : 16'h0000);
            if (tx_bitc == 3'd7) begin
              if (tx_cnt != '0) begin
                tx_sh <= tx_rdata; tx_pop <= 1'b1; tx_rp <= tx_rp + 1'b1;
                if (tx_cnt == (AW+1)'(dchan_pkg::BLOCK_BYTES)) tx_fifo_ready_irq <= 1'b1;
              end else if (tx_end_pend) begin
                tx_state <= TX_CRC; tx_crc_hi <= 1'b0;
              end else begin
                tx_state <= TX_IDLE; // underrun aborts to idle fill
                tx_fifo_ready_irq <= 1'b1;
              end
            end
          end
          TX_CRC: begin
            line_tx_bit <= ~crc[0];
            crc <= {1'b1, crc[15:1]};
            if (tx_bitc == 3'd7) begin
              tx_crc_hi <= 1'b1;
              if (tx_crc_hi) begin
                tx_state <= TX_CLOSE; tx_sh <= dchan_pkg::HDLC_FLAG;
              end
            end
          end
          default: tx_state <= TX_IDLE;
        endcase
      end
    end
  end

  byte_ram #(.DEPTH(FIFO_DEPTH), .AW(AW)) tx_ram (
    .core_clk (core_clk),
    .ce       (ce),
    .wr_en    (tx_push),
    .wr_addr  (tx_wp),
    .wr_data  (wd_reg),
    .rd_addr  (tx_rp),
    .rd_data  (tx_rdata)
  );

  // read data: fifo port, mode, counts, timer; command reads zero
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      rdata <= '0;
    end else if (ce && rd_now) begin
      if (addr_reg == dchan_pkg::RX_FIFO_OFFSET) rdata <= rx_rdata;
      else if (addr_reg == dchan_pkg::MODE_OFFSET) rdata <= mode_reg;
      else if (addr_reg == dchan_pkg::COUNT_HIGH_OFFSET) rdata <= rx_hi_reg;
      else if (addr_reg == dchan_pkg::COUNT_LOW_OFFSET) rdata <= rx_lo_reg;
      else if (addr_reg == dchan_pkg::TIMER1_OFFSET) rdata <= timer1_reg;
      else if (addr_reg == dchan_pkg::COMMAND_OFFSET) rdata <= dchan_pkg::COMMAND_RESET;
      else rdata <= {1'b0, rx_pend};
    end
  end
endmodule

// ---- testbench/dchan_checker.sv ----
`timescale 1ns/100ps
module dchan_checker (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic line_tx_bit,
  input wire logic line_tx_bit_strobe,
  input wire logic rx_block_ready_irq,
  input wire logic rx_frame_end_irq,
  input wire logic tx_fifo_ready_irq,
  input wire logic timer1_expired
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  logic [7:0] last_bits;
  // last eight bits on the wire, first sent ends up in bit 0
  always_ff @(posedge core_clk) begin
    if (line_tx_bit_strobe) last_bits <= {line_tx_bit, last_bits[7:1]};
  end
  property p_idle_ones; !line_tx_bit_strobe |-> line_tx_bit; endproperty
  a_idle_ones: assert property (p_idle_ones) else $error("idle line not high");
  property p_reset_ready; $rose(nrst) |-> ##[0:2] tx_fifo_ready_irq; endproperty
  a_reset_ready: assert property (p_reset_ready) else $error("no ready after reset");
  property p_reset_quiet; $rose(nrst) |-> line_tx_bit [*3]; endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("line low after reset");
  property p_open_flag;
    $rose(line_tx_bit_strobe) |-> !line_tx_bit ##1 line_tx_bit [*6] ##1 !line_tx_bit;
  endproperty
  a_open_flag: assert property (p_open_flag) else $error("bad opening flag");
  property p_close_flag; $fell(line_tx_bit_strobe) |-> last_bits == 8'h7e; endproperty
  a_close_flag: assert property (p_close_flag) else $error("bad closing flag");
  property p_rmr_pulse; rx_block_ready_irq |=> !rx_block_ready_irq; endproperty
  a_rmr_pulse: assert property (p_rmr_pulse) else $error("block ready too long");
  property p_rme_pulse; rx_frame_end_irq |=> !rx_frame_end_irq; endproperty
  a_rme_pulse: assert property (p_rme_pulse) else $error("frame end too long");
  property p_t1_pulse; timer1_expired |=> !timer1_expired; endproperty
  a_t1_pulse: assert property (p_t1_pulse) else $error("timer pulse too long");
  c_frame: cover property ($fell(line_tx_bit_strobe));
  c_rme: cover property (rx_frame_end_irq);
  c_t1: cover property (timer1_expired);
endmodule

// ---- testbench/host_bus.sv ----
`timescale 1ns/100ps
module host_bus (
  input  wire logic       core_clk,
  input  wire logic [7:0] rdata,
  output logic            cs_n,
  output logic            rd_n,
  output logic            wr_n,
  output logic      [5:0] addr,
  output logic      [7:0] wdata
);
  initial begin
    cs_n = 1;
    rd_n = 1;
    wr_n = 1;
    addr = 6'h3f;
    wdata = 8'h00;
  end
  // strobe held 8 cycles, address and data 4 more, then released values flip
  task automatic access(input logic wr, input logic [5:0] a, input logic [7:0] d,
                        output logic [7:0] q);
    @(negedge core_clk);
    addr = a;
    wdata = d;
    cs_n = 0;
    rd_n = wr;
    wr_n = !wr;
    repeat (8) @(posedge core_clk);
    q = rdata;
    @(negedge core_clk);
    cs_n = 1;
    rd_n = 1;
    wr_n = 1;
    repeat (4) @(negedge core_clk);
    wdata = ~d;
    addr = ~a;
    repeat (4) @(negedge core_clk);
  endtask
endmodule

// ---- testbench/dchan_hdlc_fifo_command_tb.sv ----
`timescale 1ns/100ps
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin fail_count++; \
  $display("unexpected %s exp %h got %h", n, e, g); end end
module dchan_hdlc_fifo_command_tb;
  logic       core_clk = 0;
  logic       nrst = 0;
  logic       line_rx_bit = 0;
  logic       line_rx_valid = 0;
  logic       line_rx_frame_end = 0;
  logic       cs_n, rd_n, wr_n;
  logic [5:0] addr;
  logic [7:0] wdata, rdata, q;
  logic       line_tx_bit, line_tx_bit_strobe;
  logic       rmr, rme, xfr, t1;
  logic       seen_rmr = 0, seen_rme = 0, seen_xfr = 0, seen_t1 = 0;
  logic [15:0] cap;
  int         nbits = 0, fail_count = 0, tests_run = 0;
  initial forever #12.5 core_clk = ~core_clk;
  host_bus hb (.core_clk(core_clk), .rdata(rdata), .cs_n(cs_n), .rd_n(rd_n),
               .wr_n(wr_n), .addr(addr), .wdata(wdata));
  dchan_hdlc_fifo_command DUT (.core_clk(core_clk), .nrst(nrst), .ce(1'b1),
    .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .addr(addr), .wdata(wdata), .rdata(rdata),
    .line_rx_bit(line_rx_bit), .line_rx_valid(line_rx_valid),
    .line_rx_frame_end(line_rx_frame_end), .line_tx_bit(line_tx_bit),
    .line_tx_bit_strobe(line_tx_bit_strobe), .rx_block_ready_irq(rmr),
    .rx_frame_end_irq(rme), .tx_fifo_ready_irq(xfr), .timer1_expired(t1));
  always @(posedge core_clk) begin
    if (rmr === 1'b1) seen_rmr = 1;
    if (rme === 1'b1) seen_rme = 1;
    if (xfr === 1'b1) seen_xfr = 1;
    if (t1 === 1'b1) seen_t1 = 1;
    if (line_tx_bit_strobe === 1'b1) begin
      if (nbits < 16) cap[nbits] = line_tx_bit;
      nbits++;
    end
  end
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    logic [7:0] dummy;
    hb.access(1'b1, a, d, dummy);
  endtask
  task automatic rd(input logic [5:0] a);
    hb.access(1'b0, a, 8'h00, q);
  endtask
  // bit settles one cycle before its valid edge so the two syncs cannot skew
  task automatic rx_byte(input logic [7:0] b);
    for (int i = 0; i < 8; i++) begin
      @(negedge core_clk);
      line_rx_bit = b[i];
      @(negedge core_clk);
      line_rx_valid = 1;
      repeat (3) @(negedge core_clk);
      line_rx_valid = 0;
      repeat (2) @(negedge core_clk);
    end
  endtask
  task automatic rx_end();
    @(negedge core_clk);
    line_rx_frame_end = 1;
    repeat (4) @(negedge core_clk);
    line_rx_frame_end = 0;
  endtask
  task automatic check_reset();
    `CHK("reset ready", 1'b1, seen_xfr)
    rd(dchan_pkg::COMMAND_OFFSET);
    `CHK("command", dchan_pkg::COMMAND_RESET, q)
    rd(dchan_pkg::MODE_OFFSET);
    `CHK("mode", dchan_pkg::MODE_RESET, q)
  endtask
  task automatic check_tx_frame();
    nbits = 0;
    seen_xfr = 0;
    wr(dchan_pkg::TX_FIFO_OFFSET, 8'h5a);
    wr(dchan_pkg::COMMAND_OFFSET, 8'h0a);
    for (int i = 0; i < 3000 && !seen_xfr; i++) @(posedge core_clk);
    `CHK("frame sent", 1'b1, seen_xfr)
    `CHK("open flag", dchan_pkg::HDLC_FLAG, cap[7:0])
    `CHK("data byte", 8'h5a, cap[15:8])
    `CHK("crc and close", 1'b1, nbits >= 40)
    rd(dchan_pkg::COMMAND_OFFSET);
    `CHK("self clear", 8'h00, q)
  endtask
  task automatic check_rx_frame();
    wr(dchan_pkg::MODE_OFFSET, 8'h80);
    rd(dchan_pkg::MODE_OFFSET);
    `CHK("mode rw", 8'h80, q)
    seen_rme = 0;
    rx_byte(8'ha5);
    rx_byte(8'h3c);
    rx_end();
    for (int i = 0; i < 500 && !seen_rme; i++) @(posedge core_clk);
    `CHK("frame end", 1'b1, seen_rme)
    rd(dchan_pkg::COUNT_LOW_OFFSET);
    `CHK("count low", 8'h02, q)
    rd(dchan_pkg::COUNT_HIGH_OFFSET);
    `CHK("count high", 8'h00, q)
    rd(dchan_pkg::RX_FIFO_OFFSET);
    `CHK("rx byte 0", 8'ha5, q)
    rd(dchan_pkg::RX_FIFO_OFFSET);
    `CHK("rx byte 1", 8'h3c, q)
    wr(dchan_pkg::COMMAND_OFFSET, 8'h80);
  endtask
  task automatic check_rx_block();
    seen_rmr = 0;
    for (int i = 0; i < 32; i++) rx_byte(8'(i + 1));
    for (int i = 0; i < 500 && !seen_rmr; i++) @(posedge core_clk);
    `CHK("block ready", 1'b1, seen_rmr)
    rd(6'h08);
    `CHK("pending", 8'h20, q)
    seen_rme = 0;
    rx_end();
    for (int i = 0; i < 500 && !seen_rme; i++) @(posedge core_clk);
    rd(dchan_pkg::COUNT_LOW_OFFSET);
    `CHK("count 32", 8'h20, q)
    wr(dchan_pkg::COMMAND_OFFSET, 8'h40);
    rd(6'h08);
    `CHK("pending after reset", 8'h00, q)
  endtask
  task automatic check_rx_disabled();
    wr(dchan_pkg::MODE_OFFSET, 8'h00);
    seen_rme = 0;
    rx_byte(8'h11);
    rx_end();
    repeat (200) @(posedge core_clk);
    `CHK("rx disabled", 1'b0, seen_rme)
  endtask
  task automatic check_timer_txreset();
    seen_t1 = 0;
    wr(dchan_pkg::TIMER1_OFFSET, 8'h02);
    wr(dchan_pkg::COMMAND_OFFSET, 8'h10);
    for (int i = 0; i < 1000 && !seen_t1; i++) @(posedge core_clk);
    `CHK("timer expired", 1'b1, seen_t1)
    seen_t1 = 0;
    wr(dchan_pkg::COMMAND_OFFSET, 8'h10);
    wr(dchan_pkg::TIMER1_OFFSET, 8'h02);
    repeat (200) @(posedge core_clk);
    `CHK("timer stopped", 1'b0, seen_t1)
    wr(dchan_pkg::TX_FIFO_OFFSET, 8'h33);
    seen_xfr = 0;
    nbits = 0;
    wr(dchan_pkg::COMMAND_OFFSET, 8'h01);
    repeat (200) @(posedge core_clk);
    `CHK("tx reset ready", 1'b1, seen_xfr)
    `CHK("fill only", 0, nbits)
    seen_xfr = 0;
    nbits = 0;
    wr(dchan_pkg::TX_FIFO_OFFSET, 8'hc3);
    wr(dchan_pkg::COMMAND_OFFSET, 8'h0a);
    for (int i = 0; i < 3000 && !seen_xfr; i++) @(posedge core_clk);
    `CHK("fifo emptied", 8'hc3, cap[15:8])
  endtask
  task automatic conclude();
    if (fail_count == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    repeat (2) @(negedge core_clk);
    nrst = 1;
    repeat (4) @(negedge core_clk);
    check_reset();
    check_tx_frame();
    check_rx_frame();
    check_rx_block();
    check_rx_disabled();
    check_timer_txreset();
    conclude();
  end
  initial begin
    repeat (30000) @(posedge core_clk);
    fail_count++;
    conclude();
  end
endmodule
bind dchan_hdlc_fifo_command dchan_checker u_chk (.core_clk(core_clk), .nrst(nrst),
  .line_tx_bit(line_tx_bit), .line_tx_bit_strobe(line_tx_bit_strobe),
  .rx_block_ready_irq(rx_block_ready_irq), .rx_frame_end_irq(rx_frame_end_irq),
  .tx_fifo_ready_irq(tx_fifo_ready_irq), .timer1_expired(timer1_expired));
